// ### gated_photon_counters.sv
// Gated counting core: discriminators, counters A and B, interval counter T
module gated_photon_counters
    import gpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic comp_a,
    input wire logic comp_b1,
    input wire logic comp_b2,
    input wire logic comp_t,
    input wire logic comp_trig,
    input wire logic gate_a_n,
    input wire logic gate_b_n,
    input wire logic comparator_freeze,
    output logic period_done,
    output logic window_open,
    output logic rollover_a,
    output logic rollover_b,
    output logic t_disc_out,
    output logic t_output_suppress
);

    // ========================================
    // Helpers
    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // ========================================
    // Declarations
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] sync1_q;
    logic [PIN_W-1:0] sync2_q;
    logic disc_a_q;
    logic disc_b_q;
    logic disc_t_q;
    logic disc_trig_q;
    logic prev_a_q;
    logic prev_b_q;
    logic prev_t_q;
    logic prev_trig_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [31:0] t_preset_value_q;
    logic [31:0] b_preset_value_q;
    logic [31:0] t_left_q;
    logic [TB_W-1:0] tb_cnt_q;
    logic tb_tick;
    logic tb_level_q;
    logic window_q;
    logic done_q;
    logic done_pulse_q;
    logic tdisc_q;
    logic clear_q;
    logic preload_q;
    period_state_t state_q;
    logic signal_input_block_a;
    logic timebase_block_a;
    logic slope_invert_a;
    logic slope_invert_b;
    logic b_input_sel;
    logic continuous_gate;
    logic b_preset_mode;
    t_src_t t_src;
    logic wr_cmd;
    logic cmd_clear;
    logic prescale_hold_strobe;
    logic cmd_arm;
    logic halt_n;
    logic done_rearm_n;
    logic a_src_edge;
    logic b_edge;
    logic t_edge;
    logic gate_a_eff_n;
    logic a_window_n;
    logic b_window_n;
    logic [1:0] count_pulse;
    logic [1:0] rollover;
    chan_t chan [2];
    logic [31:0] t_preset_value;
    logic [31:0] b_preset_value;
    logic [31:0] t_reload;
    logic close_now;

    // ========================================
    // Control decode
    assign signal_input_block_a = ctrl_q[CTRL_SIG_BLK_A];
    assign timebase_block_a = ctrl_q[CTRL_TB_BLK_A];
    assign slope_invert_a = ctrl_q[CTRL_INV_A];
    assign slope_invert_b = ctrl_q[CTRL_INV_B];
    assign b_input_sel = ctrl_q[CTRL_B_SEL];
    assign continuous_gate = ctrl_q[CTRL_CONT_GATE];
    assign b_preset_mode = ctrl_q[CTRL_B_PRESET];
    assign t_src = t_src_t'(ctrl_q[CTRL_TSRC_LSB +: 2]);
    assign t_preset_value = t_preset_value_q;
    assign b_preset_value = b_preset_value_q;

    assign wr_cmd = reg_wr & hit(reg_addr, CMD_OFS);
    assign cmd_clear = wr_cmd & reg_wdata[CMD_CLEAR];
    assign prescale_hold_strobe = wr_cmd & reg_wdata[CMD_HOLD];
    assign cmd_arm = wr_cmd & reg_wdata[CMD_ARM];
    assign halt_n = ~(wr_cmd & reg_wdata[CMD_HALT]);
    assign done_rearm_n = ~(wr_cmd & reg_wdata[CMD_REARM]);

    // ========================================
    // Pin synchronisers
    assign pins = {comparator_freeze, gate_b_n, gate_a_n, comp_trig,
                   comp_t, comp_b2, comp_b1, comp_a};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    // ========================================
    // Discriminator outputs
    // freeze holds last state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            disc_a_q <= 1'b0;
            disc_b_q <= 1'b0;
            disc_t_q <= 1'b0;
            disc_trig_q <= 1'b0;
        end else if (!sync2_q[PIN_FREEZE]) begin
            disc_a_q <= sync2_q[PIN_A] ^ slope_invert_a;
            disc_b_q <= (b_input_sel ? sync2_q[PIN_B2] : sync2_q[PIN_B1]) ^ slope_invert_b;
            disc_t_q <= sync2_q[PIN_T];
            disc_trig_q <= sync2_q[PIN_TRIG];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_a_q <= 1'b0;
            prev_b_q <= 1'b0;
            prev_t_q <= 1'b0;
            prev_trig_q <= 1'b0;
        end else begin
            prev_a_q <= disc_a_q;
            prev_b_q <= disc_b_q;
            prev_t_q <= disc_t_q;
            prev_trig_q <= disc_trig_q;
        end
    end

    // ========================================
    // 10 MHz timebase as a tick enable
    assign tb_tick = (tb_cnt_q == TB_W'(TB_DIV - 1));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tb_cnt_q <= '0;
            tb_level_q <= 1'b0;
        end else begin
            tb_cnt_q <= tb_tick ? '0 : tb_cnt_q + TB_W'(1);
            tb_level_q <= (tb_cnt_q < TB_W'(TB_DIV / 2));
        end
    end

    // ========================================
    // Counter input selection and gating
    // per-source block signals
    assign a_src_edge = (rise(disc_a_q, prev_a_q) & ~signal_input_block_a)
                      | (tb_tick & ~timebase_block_a);
    assign b_edge = rise(disc_b_q, prev_b_q);

    assign gate_a_eff_n = continuous_gate ? 1'b0 : sync2_q[PIN_GATE_A_N];
    assign a_window_n = ~window_q;
    assign b_window_n = b_preset_mode ? 1'b0 : ~window_q;

    assign count_pulse[0] = a_src_edge & ~gate_a_eff_n & ~a_window_n;
    assign count_pulse[1] = b_edge & ~sync2_q[PIN_GATE_B_N] & ~b_window_n;

    // ========================================
    // Counters A and B
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            counter_chain u_chain (
                .sys_clk(sys_clk),
                .rst(rst),
                .clear(clear_q),
                .preload(preload_q),
                .count_pulse(count_pulse[gi]),
                .hold_strobe(prescale_hold_strobe),
                .chan(chan[gi]),
                .rollover(rollover[gi])
            );
        end
    endgenerate

    assign rollover_a = rollover[0];
    assign rollover_b = rollover[1];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clear_q <= 1'b0;
            preload_q <= 1'b0;
        end else begin
            clear_q <= cmd_clear | ~done_rearm_n;
            preload_q <= clear_q;
        end
    end

    // ========================================
    // T counter source
    // four-way source select
    // B preset with the TSRC_BGATED source routes B into T
    always_comb begin
        case (t_src)
            TSRC_TIMEBASE: t_edge = tb_tick;
            TSRC_TRIGGER: t_edge = rise(disc_trig_q, prev_trig_q);
            TSRC_TDISC: t_edge = rise(disc_t_q, prev_t_q);
            TSRC_BGATED: t_edge = b_preset_mode & b_edge & ~sync2_q[PIN_GATE_B_N];
            default: t_edge = 1'b0;
        endcase
    end

    assign t_output_suppress = b_preset_mode;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tdisc_q <= 1'b0;
        end else begin
            tdisc_q <= (t_src == TSRC_TIMEBASE ? tb_level_q : disc_t_q) & ~t_output_suppress;
        end
    end

    assign t_disc_out = tdisc_q;

    // ========================================
    // Count period sequence
    assign t_reload = b_preset_mode ? b_preset_value : t_preset_value;
    assign close_now = (state_q == ST_COUNTING)
                     && ((t_edge && t_left_q <= 32'h0000_0001) || !halt_n);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd_arm) begin
                        state_q <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (!halt_n) begin
                        state_q <= ST_DONE;
                    end else if (t_edge) begin
                        state_q <= ST_COUNTING;
                    end
                end
                ST_COUNTING: begin
                    if (close_now) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!done_rearm_n) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            window_q <= 1'b0;
        end else if (state_q == ST_ARMED && t_edge && halt_n) begin
            window_q <= 1'b1;
        end else if (close_now || state_q != ST_COUNTING) begin
            window_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            t_left_q <= T_PRESET_VALUE_RST;
        end else if (close_now || (state_q == ST_ARMED && !halt_n) || state_q == ST_IDLE) begin
            t_left_q <= t_reload;
        end else if (state_q == ST_COUNTING && t_edge) begin
            t_left_q <= t_left_q - 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
            done_pulse_q <= 1'b0;
        end else begin
            done_pulse_q <= close_now || (state_q == ST_ARMED && !halt_n);
            if (close_now || (state_q == ST_ARMED && !halt_n)) begin
                done_q <= 1'b1;
            end else if (!done_rearm_n) begin
                done_q <= 1'b0;
            end
        end
    end

    assign period_done = done_pulse_q;
    assign window_open = window_q;

    // ========================================
    // Register writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            t_preset_value_q <= T_PRESET_VALUE_RST;
            b_preset_value_q <= B_PRESET_VALUE_RST;
        end else if (reg_wr) begin
            if (hit(reg_addr, CTRL_OFS)) begin
                ctrl_q <= reg_wdata[CTRL_W-1:0];
            end
            if (hit(reg_addr, T_PRESET_VALUE_OFS)) begin
                t_preset_value_q <= reg_wdata;
            end
            if (hit(reg_addr, B_PRESET_VALUE_OFS)) begin
                b_preset_value_q <= reg_wdata;
            end
        end
    end

    // ========================================
    // Register reads, data valid only in the following cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else begin
            case (reg_addr)
                CTRL_OFS: reg_rdata <= {{(DATA_W - CTRL_W){1'b0}}, ctrl_q};
                T_PRESET_VALUE_OFS: reg_rdata <= t_preset_value_q;
                B_PRESET_VALUE_OFS: reg_rdata <= b_preset_value_q;
                STAT_OFS: reg_rdata <= {26'h0, t_output_suppress, state_q == ST_ARMED,
                                        done_q, window_q, state_q};
                HOLD_OFS: reg_rdata <= {18'h0, chan[1].held, 2'h0, chan[0].held};
                A_MID_OFS: reg_rdata <= {19'h0, chan[0].mid};
                B_MID_OFS: reg_rdata <= {19'h0, chan[1].mid};
                A_UP_OFS: reg_rdata <= chan[0].upper;
                B_UP_OFS: reg_rdata <= chan[1].upper;
                T_LEFT_OFS: reg_rdata <= t_left_q;
                default: reg_rdata <= '0;
            endcase
        end
    end

endmodule

// ### gpc_pkg.sv
// Shared constants, types and register map of the gated photon counters
package gpc_pkg;

    // ========================================
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] T_PRESET_VALUE_OFS = 8'h08;
    localparam logic [7:0] B_PRESET_VALUE_OFS = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] HOLD_OFS = 8'h14;
    localparam logic [7:0] A_MID_OFS = 8'h18;
    localparam logic [7:0] B_MID_OFS = 8'h1C;
    localparam logic [7:0] A_UP_OFS = 8'h20;
    localparam logic [7:0] B_UP_OFS = 8'h24;
    localparam logic [7:0] T_LEFT_OFS = 8'h28;

    // ========================================
    // Control register fields
    localparam int CTRL_SIG_BLK_A = 0;
    localparam int CTRL_TB_BLK_A = 1;
    localparam int CTRL_INV_A = 2;
    localparam int CTRL_INV_B = 3;
    localparam int CTRL_B_SEL = 4;
    localparam int CTRL_CONT_GATE = 5;
    localparam int CTRL_B_PRESET = 6;
    localparam int CTRL_TSRC_LSB = 7;
    localparam int CTRL_W = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

    // Command register bits, each a one-cycle action
    localparam int CMD_CLEAR = 0;
    localparam int CMD_HOLD = 1;
    localparam int CMD_ARM = 2;
    localparam int CMD_HALT = 3;
    localparam int CMD_REARM = 4;

    localparam logic [31:0] T_PRESET_VALUE_RST = 32'h0000_0001;
    localparam logic [31:0] B_PRESET_VALUE_RST = 32'h0000_0001;

    // ========================================
    // Timing and counter geometry
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int TIMEBASE_HZ = 10_000_000;
    localparam int TB_DIV = SYS_CLK_HZ / TIMEBASE_HZ;
    localparam int TB_W = 4;
    localparam int LOW_BITS = 6;
    localparam int MID_DIV = 6250;
    localparam int MID_W = 13;
    localparam int UP_W = 32;
    localparam logic [MID_W-1:0] MID_START = MID_W'(MID_DIV - 1);

    // Pin vector positions
    localparam int PIN_A = 0;
    localparam int PIN_B1 = 1;
    localparam int PIN_B2 = 2;
    localparam int PIN_T = 3;
    localparam int PIN_TRIG = 4;
    localparam int PIN_GATE_A_N = 5;
    localparam int PIN_GATE_B_N = 6;
    localparam int PIN_FREEZE = 7;
    localparam int PIN_W = 8;

    // ========================================
    // Types
    typedef enum logic [1:0] {
        TSRC_TIMEBASE,
        TSRC_TRIGGER,
        TSRC_TDISC,
        TSRC_BGATED
    } t_src_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_COUNTING,
        ST_DONE
    } period_state_t;

    typedef struct packed {
        logic [LOW_BITS-1:0] low;
        logic [LOW_BITS-1:0] held;
        logic [MID_W-1:0] mid;
        logic [UP_W-1:0] upper;
    } chan_t;

endpackage

// ### counter_chain.sv
// One gated event counter: prescale bits, divide-by-6250 middle stage, upper word
module counter_chain
    import gpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic preload,
    input wire logic count_pulse,
    input wire logic hold_strobe,
    output chan_t chan,
    output logic rollover
);

    logic div2a_q;
    logic div2b_q;
    logic [3:0] div16_q;
    logic [MID_W-1:0] mid_q;
    logic [UP_W-1:0] up_q;
    logic [LOW_BITS-1:0] held_q;
    logic roll_q;
    logic low_carry;
    logic mid_wrap;

    assign low_carry = count_pulse & div2a_q & div2b_q & (div16_q == 4'hF);
    assign mid_wrap = low_carry & (mid_q == '0);

    // ========================================
    // Prescale stages
    // two halvers then sixteen
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div2a_q <= 1'b0;
            div2b_q <= 1'b0;
            div16_q <= 4'h0;
        end else if (clear) begin
            div2a_q <= 1'b0;
            div2b_q <= 1'b0;
            div16_q <= 4'h0;
        end else if (count_pulse) begin
            div2a_q <= ~div2a_q;
            if (div2a_q) begin
                div2b_q <= ~div2b_q;
            end
            if (div2a_q && div2b_q) begin
                div16_q <= div16_q + 4'h1;
            end
        end
    end

    // ========================================
    // Middle stage, counts down
    // divide carries by 6250
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mid_q <= '0;
        end else if (clear) begin
            mid_q <= '0;
        end else if (preload) begin
            mid_q <= MID_START;
        end else if (mid_wrap) begin
            mid_q <= MID_START;
        end else if (low_carry) begin
            mid_q <= mid_q - MID_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            up_q <= '0;
            roll_q <= 1'b0;
        end else begin
            roll_q <= mid_wrap & ~clear & ~preload;
            if (clear) begin
                up_q <= '0;
            end else if (mid_wrap && !preload) begin
                up_q <= up_q + UP_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            held_q <= '0;
        end else if (hold_strobe) begin
            held_q <= {div16_q, div2b_q, div2a_q};
        end
    end

    assign chan.low = {div16_q, div2b_q, div2a_q};
    assign chan.held = held_q;
    assign chan.mid = mid_q;
    assign chan.upper = up_q;
    assign rollover = roll_q;

endmodule

// ### gpc_props.sv
// Port checker of the gated photon counters
module gpc_props import gpc_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic period_done,
    input wire logic window_open,
    input wire logic rollover_a,
    input wire logic rollover_b,
    input wire logic t_disc_out,
    input wire logic t_output_suppress
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ========
    // Period end
    sequence s_quiet;
        !window_open ##1 !period_done [*4];
    endsequence
    sequence s_stat_rd;
        $past(reg_rd) && ($past(reg_addr) == STAT_OFS);
    endsequence
    property p_done_close;
        $fell(window_open) |-> ##[0:1] period_done;
    endproperty
    a_done_close: assert property (p_done_close) else $error("no done at close");
    property p_done_quiet;
        period_done |-> s_quiet;
    endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("window after done");

    // ========
    // Rollover events
    property p_roll_a;
        rollover_a |=> !rollover_a [*8];
    endproperty
    a_roll_a: assert property (p_roll_a) else $error("A rollover repeated");
    property p_roll_b;
        rollover_b |=> !rollover_b [*8];
    endproperty
    a_roll_b: assert property (p_roll_b) else $error("B rollover repeated");

    // ========
    // Output suppression and status
    property p_suppress;
        t_output_suppress [*3] |-> !t_disc_out;
    endproperty
    a_suppress: assert property (p_suppress) else $error("T output not off");
    property p_stat_win;
        s_stat_rd |-> reg_rdata[2] == $past(window_open);
    endproperty
    a_stat_win: assert property (p_stat_win) else $error("status window bit");
    property p_stat_sup;
        s_stat_rd |-> reg_rdata[5] == $past(t_output_suppress);
    endproperty
    a_stat_sup: assert property (p_stat_sup) else $error("status suppress bit");
    // Data only in the cycle after a read, so a stale hold value never leaks
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
endmodule

bind gated_photon_counters gpc_props u_props (
    .sys_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .period_done, .window_open,
    .rollover_a, .rollover_b, .t_disc_out, .t_output_suppress
);

// ### gpc_pulse_src.sv
// Discriminated pulse source standing in for the input pins
module gpc_pulse_src (
    input wire logic sys_clk,
    output logic comp_a,
    output logic comp_b1,
    output logic comp_b2,
    output logic comp_t,
    output logic comp_trig
);
    timeunit 1ns;
    timeprecision 1ns;
    // Second input stays quiet so selecting it must count nothing
    assign comp_b2 = 1'b0;
    initial {comp_t, comp_trig, comp_a, comp_b1} = 4'h0;

    // One 10 cycle slot: T and trigger pulse, or A and B pulse
    task automatic step(input logic t);
        @(posedge sys_clk);
        comp_t <= t;
        comp_trig <= t;
        comp_a <= !t;
        comp_b1 <= !t;
        repeat (2) @(posedge sys_clk);
        {comp_t, comp_trig, comp_a, comp_b1} <= 4'h0;
        repeat (7) @(posedge sys_clk);
    endtask

    // Each T pulse followed by two A and B pulses
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            step(1'b1);
            step(1'b0);
            step(1'b0);
        end
    endtask
endmodule

// ### gated_photon_counters_test.sv
// Self-checking bench of the gated photon counters
module gated_photon_counters_test import gpc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic gate_a_n = 1'b0;
    logic gate_b_n = 1'b0;
    logic comparator_freeze = 1'b0;
    logic [31:0] reg_rdata;
    logic comp_a, comp_b1, comp_b2, comp_t, comp_trig;
    logic period_done, window_open, rollover_a, rollover_b, t_disc_out, t_output_suppress;
    logic [31:0] d;
    int mismatches = 0;
    int checked = 0;
    int rolls = 0;
    logic [7:0] rst_addr [6] = '{CTRL_OFS, CMD_OFS, T_PRESET_VALUE_OFS, B_PRESET_VALUE_OFS, STAT_OFS, 8'h3C};
    logic [31:0] rst_val [6] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};
    // Trigger or T disc source; slopes, gating, continuous gate, input select, blocks
    // First set counts on the trailing pin edge, which still falls inside the window
    logic [31:0] cfg_ctrl [4] = '{32'h08E, 32'h132, 32'h102, 32'h103};
    logic cfg_gate [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [5:0] exp_a [4] = '{6'h06, 6'h06, 6'h00, 6'h00};
    logic [5:0] exp_b [4] = '{6'h06, 6'h00, 6'h06, 6'h06};

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rollover_a === 1'b1) rolls++;

    gated_photon_counters dut (
        .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .comp_a, .comp_b1, .comp_b2, .comp_t, .comp_trig, .gate_a_n, .gate_b_n,
        .comparator_freeze, .period_done, .window_open, .rollover_a, .rollover_b,
        .t_disc_out, .t_output_suppress
    );
    gpc_pulse_src src (.sys_clk, .comp_a, .comp_b1, .comp_b2, .comp_t, .comp_trig);

    // ========
    // Bench tasks
    task automatic finish_test();
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Done is a single-cycle pulse, so poll every cycle
    task automatic wait_done(input int n);
        int i;
        for (i = 0; i < n && period_done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (i == n) begin
            mismatches++;
            finish_test();
        end
    endtask
    task automatic rearm();
        wr(CMD_OFS, 32'h10);
        repeat (3) @(posedge sys_clk);
        rd(STAT_OFS, d);
        check(d[1:0], 2'h0);
    endtask

    // ========
    // Scenarios
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(rst_addr[i], d);
            check(d, rst_val[i]);
        end
        wr(T_PRESET_VALUE_OFS, 32'h3);
        for (int i = 0; i < 4; i++) begin
            wr(CTRL_OFS, cfg_ctrl[i]);
            gate_a_n <= cfg_gate[i];
            wr(CMD_OFS, 32'h4);
            rd(STAT_OFS, d);
            check(d[4:0], 5'h11);
            fork
                src.burst(4);
                wait_done(400);
            join
            rd(STAT_OFS, d);
            check(d[3:0], 4'hB);
            rd(T_LEFT_OFS, d);
            check(d, 32'h3);
            wr(CMD_OFS, 32'h2);
            rd(HOLD_OFS, d);
            check(d[5:0], exp_a[i]);
            check(d[13:8], exp_b[i]);
            rearm();
            rd(A_MID_OFS, d);
            check(d, 32'(MID_START));
        end
        comparator_freeze <= 1'b1;
        wr(CMD_OFS, 32'h4);
        src.burst(2);
        rd(STAT_OFS, d);
        check(d[1:0], 2'h1);
        fork
            wr(CMD_OFS, 32'h8);
            wait_done(20);
        join
        rd(STAT_OFS, d);
        check(d[1:0], 2'h3);
        rearm();
        comparator_freeze <= 1'b0;
        // Reset leaves the middle stage unloaded, so the first carry wraps it
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        wr(CTRL_OFS, 32'h1);
        wr(T_PRESET_VALUE_OFS, 32'd100);
        wr(CMD_OFS, 32'h4);
        fork
            repeat (70) src.step(1'b0);
            wait_done(1500);
        join
        rd(A_UP_OFS, d);
        check(d, 32'h1);
        rd(B_UP_OFS, d);
        check(d, 32'h1);
        rd(A_MID_OFS, d);
        check(d, 32'(MID_START));
        check(rolls, 32'h1);
        wr(CMD_OFS, 32'h1);
        rd(A_UP_OFS, d);
        check(d, 32'h0);
        rd(A_MID_OFS, d);
        check(d, 32'(MID_START));
        rearm();
        wr(CTRL_OFS, 32'h1C0);
        wr(B_PRESET_VALUE_OFS, 32'h2);
        check(t_output_suppress, 1'b1);
        check(t_disc_out, 1'b0);
        wr(CMD_OFS, 32'h4);
        fork
            repeat (6) src.step(1'b0);
            wait_done(100);
        join
        rd(STAT_OFS, d);
        check(d[5:0], 6'h2B);
        rearm();
        finish_test();
    end
endmodule
